// [core/fefc_regs.svh]
/*
 * bit layout, views and reset values of the fp control/status register.
 * assumes: included by bare name from the exception control module.
 */
`ifndef FEFC_REGS_SVH
`define FEFC_REGS_SVH

// ----------------------------------------
// full register image field positions
// ----------------------------------------
`define FEFC_FS_BIT        24
`define FEFC_FO_BIT        22
`define FEFC_FN_BIT        21
`define FEFC_ABS_BIT       19
`define FEFC_NAN_BIT       18
`define FEFC_CAUSE_HI      17
`define FEFC_CAUSE_LO      12
`define FEFC_EN_HI         11
`define FEFC_EN_LO         7
`define FEFC_FLAG_HI       6
`define FEFC_FLAG_LO       2
`define FEFC_RM_HI         1
`define FEFC_RM_LO         0

// ----------------------------------------
// alias views
// ----------------------------------------
`define FEFC_VIEW_FULL     2'h0
`define FEFC_VIEW_EXC      2'h1
`define FEFC_VIEW_ENR      2'h2
`define FEFC_ENR_FS_BIT    2

// ----------------------------------------
// cause vector layout and reset values
// ----------------------------------------
`define FEFC_CAUSE_E       5
`define FEFC_CAUSE_RST     6'h00
`define FEFC_EN_RST        5'h00
`define FEFC_FLAG_RST      5'h00
`define FEFC_RM_RST        2'h0
`define FEFC_CTL_RST       1'h0
`define FEFC_WORD_ZERO     32'h0000_0000
`define FEFC_FIXED_ONE     1'h1

`endif

// [core/fefc_pkg.sv]
/*
 * types shared by the exception/flush control modules.
 * assumes: nothing beyond a systemverilog compiler.
 */
package fefc_pkg;

	// instruction class as seen by the flush logic
	typedef enum logic [1:0] {
		FEFC_OP_OTHER  = 2'h0,
		FEFC_OP_ARITH  = 2'h1,
		FEFC_OP_MADD   = 2'h2,
		FEFC_OP_ABSNEG = 2'h3
	} fefc_op_e;

	// rounding field encodings
	typedef enum logic [1:0] {
		FEFC_ROUND_NEAREST_EVEN    = 2'h0,
		FEFC_ROUND_TOWARD_ZERO     = 2'h1,
		FEFC_ROUND_TOWARD_PLUS_INF = 2'h2,
		FEFC_ROUND_TOWARD_MINUS    = 2'h3
	} fefc_round_e;

	// value forced onto a tiny result
	typedef enum logic [1:0] {
		FEFC_FORCE_NONE     = 2'h0,
		FEFC_FORCE_ZERO     = 2'h1,
		FEFC_FORCE_MIN_NORM = 2'h2
	} fefc_force_e;

endpackage

// [core/fefc_flush_if.sv]
/*
 * carrier between the register block and the flush decision unit.
 * assumes: both ends on core_clk, decision is purely combinational.
 */
`timescale 1ns/10ps

interface fefc_flush_if;
	fefc_pkg::fefc_round_e rounding_field;
	logic                  flush_to_zero_ctl;
	logic                  flush_override_ctl;
	logic                  flush_nearest_ctl;
	fefc_pkg::fefc_op_e    kind;
	logic                  denorm_in;
	logic                  tiny_inter;
	logic                  tiny_final;
	logic                  sign;
	logic                  below_half;
	logic                  flush_operands;
	logic                  unimpl;
	fefc_pkg::fefc_force_e inter_force;
	fefc_pkg::fefc_force_e final_force;

	modport ctl (
		output rounding_field, flush_to_zero_ctl, flush_override_ctl,
		output flush_nearest_ctl, kind, denorm_in, tiny_inter, tiny_final,
		output sign, below_half,
		input  flush_operands, unimpl, inter_force, final_force
	);
	modport unit (
		input  rounding_field, flush_to_zero_ctl, flush_override_ctl,
		input  flush_nearest_ctl, kind, denorm_in, tiny_inter, tiny_final,
		input  sign, below_half,
		output flush_operands, unimpl, inter_force, final_force
	);
endinterface

// [core/fefc_flush_unit.sv]
/*
 * denormal operand and tiny result decision logic.
 * assumes: driven through fefc_flush_if by the control register block.
 */
`timescale 1ns/10ps

module fefc_flush_unit (
	fefc_flush_if.unit fl
);

	// ----------------------------------------
	// tiny result value by rounding mode
	// ----------------------------------------
	function automatic fefc_pkg::fefc_force_e by_mode(
		input fefc_pkg::fefc_round_e rm,
		input logic                  neg
	);
		fefc_pkg::fefc_force_e f;
		case (rm)
			fefc_pkg::FEFC_ROUND_TOWARD_PLUS_INF: begin
				f = neg ? fefc_pkg::FEFC_FORCE_ZERO : fefc_pkg::FEFC_FORCE_MIN_NORM;
			end
			fefc_pkg::FEFC_ROUND_TOWARD_MINUS: begin
				f = neg ? fefc_pkg::FEFC_FORCE_MIN_NORM : fefc_pkg::FEFC_FORCE_ZERO;
			end
			default: begin
				f = fefc_pkg::FEFC_FORCE_ZERO;
			end
		endcase
		return f;
	endfunction

	logic trapping;
	logic affected;
	logic is_madd;

	// ----------------------------------------
	// class decode
	// ----------------------------------------
	// only arithmetic and multiply-add may trap on denormals
	assign trapping = (fl.kind == fefc_pkg::FEFC_OP_ARITH) ||
		(fl.kind == fefc_pkg::FEFC_OP_MADD);
	assign affected = trapping || (fl.kind == fefc_pkg::FEFC_OP_ABSNEG);
	assign is_madd  = (fl.kind == fefc_pkg::FEFC_OP_MADD);

	// ----------------------------------------
	// decisions
	// ----------------------------------------
	// tiny flags come from a value rounded with unbounded exponent
	always_comb begin
		fl.flush_operands = affected && fl.flush_to_zero_ctl;
		fl.unimpl         = 1'b0;
		fl.inter_force    = fefc_pkg::FEFC_FORCE_NONE;
		fl.final_force    = fefc_pkg::FEFC_FORCE_NONE;
		// denormal operand without flushing
		if (trapping && fl.denorm_in && !fl.flush_to_zero_ctl) begin
			fl.unimpl = 1'b1;
		end
		// multiply-add intermediate: override keeps it untouched
		if (is_madd && fl.tiny_inter && !fl.flush_override_ctl) begin
			if (fl.flush_to_zero_ctl) begin
				fl.inter_force = by_mode(fl.rounding_field, fl.sign);
			end else begin
				fl.unimpl = 1'b1;
			end
		end
		// final result: nearest flush wins over zero flush
		if (affected && fl.tiny_final) begin
			if (fl.flush_nearest_ctl &&
				fl.rounding_field == fefc_pkg::FEFC_ROUND_NEAREST_EVEN) begin
				fl.final_force = fl.below_half ? fefc_pkg::FEFC_FORCE_ZERO :
					fefc_pkg::FEFC_FORCE_MIN_NORM;
			end else if (fl.flush_nearest_ctl || fl.flush_to_zero_ctl) begin
				fl.final_force = by_mode(fl.rounding_field, fl.sign);
			end else if (trapping) begin
				fl.unimpl = 1'b1;
			end
		end
	end

endmodule // fefc_flush_unit

// [core/fefc_exc_ctrl.sv]
/*
 * fp control/status register with cause, enable and sticky flag fields,
 * trap generation and flush control for denormals and tiny results.
 * assumes: core pipeline on core_clk drives writes and op reports,
 * with synchronous active-high reset; no synchronisers needed.
 */
`timescale 1ns/10ps
`include "fefc_regs.svh"


module fefc_exc_ctrl (
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        csr_wr_en,
	input  wire logic [1:0]  csr_wr_view,
	input  wire logic [31:0] csr_wr_data,
	input  wire logic        op_valid,
	input  wire logic [1:0]  op_kind,
	input  wire logic [4:0]  op_ieee_exc,
	input  wire logic        op_denorm_in,
	input  wire logic        op_tiny_inter,
	input  wire logic        op_tiny_final,
	input  wire logic        op_sign,
	input  wire logic        op_below_half,
	output logic      [31:0] csr_rd_data_ff,
	output logic             trap_ff,
	output logic             trap_unimpl_ff,
	output logic             flush_operands_ff,
	output logic      [1:0]  inter_force_ff,
	output logic      [1:0]  final_force_ff,
	output logic             result_sign_ff,
	output logic      [1:0]  rounding_field_ff
);

	// ----------------------------------------
	// register fields
	// ----------------------------------------
	logic [5:0]  cause_ff;
	logic [4:0]  enables_ff;
	logic [4:0]  flags_ff;
	logic        flush_to_zero_ctl_ff;
	logic        flush_override_ctl_ff;
	logic        flush_nearest_ctl_ff;

	logic [5:0]  nxt_cause;
	logic [4:0]  nxt_enables;
	logic [4:0]  nxt_flags;
	logic        nxt_fs;
	logic        nxt_fo;
	logic        nxt_fn;
	logic [1:0]  nxt_rm;
	logic [31:0] nxt_rd_data;

	// ----------------------------------------
	// outputs toward the core
	// ----------------------------------------
	logic        nxt_trap;
	logic        nxt_trap_unimpl;
	logic        nxt_flush_operands;
	logic [1:0]  nxt_inter_force;
	logic [1:0]  nxt_final_force;
	logic        nxt_result_sign;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	logic [5:0]  wr_cause;
	logic [4:0]  wr_flags;
	logic [4:0]  op_enabled_hits;
	logic [5:0]  op_cause;
	logic        op_trap;
	logic        wr_trap;

	fefc_flush_if fl ();

	// ----------------------------------------
	// flush decision unit
	// ----------------------------------------
	// decisions use the settings in force before any same-cycle write
	assign fl.rounding_field     = fefc_pkg::fefc_round_e'(rounding_field_ff);
	assign fl.flush_to_zero_ctl  = flush_to_zero_ctl_ff;
	assign fl.flush_override_ctl = flush_override_ctl_ff;
	assign fl.flush_nearest_ctl  = flush_nearest_ctl_ff;
	assign fl.kind               = fefc_pkg::fefc_op_e'(op_kind);
	assign fl.denorm_in          = op_denorm_in;
	assign fl.tiny_inter         = op_tiny_inter;
	assign fl.tiny_final         = op_tiny_final;
	assign fl.sign               = op_sign;
	assign fl.below_half         = op_below_half;

	fefc_flush_unit u_flush (
		.fl (fl.unit)
	);

	// ----------------------------------------
	// register write decode
	// ----------------------------------------
	// each view touches only its own fields
	always_comb begin
		nxt_enables = enables_ff;
		nxt_fs      = flush_to_zero_ctl_ff;
		nxt_fo      = flush_override_ctl_ff;
		nxt_fn      = flush_nearest_ctl_ff;
		nxt_rm      = rounding_field_ff;
		wr_cause    = cause_ff;
		wr_flags    = flags_ff;
		if (csr_wr_en) begin
			case (csr_wr_view)
				`FEFC_VIEW_FULL: begin
					wr_cause    = csr_wr_data[`FEFC_CAUSE_HI:`FEFC_CAUSE_LO];
					nxt_enables = csr_wr_data[`FEFC_EN_HI:`FEFC_EN_LO];
					wr_flags    = csr_wr_data[`FEFC_FLAG_HI:`FEFC_FLAG_LO];
					nxt_fs      = csr_wr_data[`FEFC_FS_BIT];
					nxt_fo      = csr_wr_data[`FEFC_FO_BIT];
					nxt_fn      = csr_wr_data[`FEFC_FN_BIT];
					nxt_rm      = csr_wr_data[`FEFC_RM_HI:`FEFC_RM_LO];
				end
				`FEFC_VIEW_EXC: begin
					wr_cause  = csr_wr_data[`FEFC_CAUSE_HI:`FEFC_CAUSE_LO];
					wr_flags  = csr_wr_data[`FEFC_FLAG_HI:`FEFC_FLAG_LO];
				end
				`FEFC_VIEW_ENR: begin
					nxt_enables = csr_wr_data[`FEFC_EN_HI:`FEFC_EN_LO];
					nxt_fs      = csr_wr_data[`FEFC_ENR_FS_BIT];
					nxt_rm      = csr_wr_data[`FEFC_RM_HI:`FEFC_RM_LO];
				end
				default: begin
					wr_cause = cause_ff; // unmapped view: nothing stored
				end
			endcase
		end
	end

	// ----------------------------------------
	// trap evaluation
	// ----------------------------------------
	// write trap looks at cause and enables as they stand after the write, any view
	assign wr_trap = csr_wr_en &&
		((|(wr_cause[4:0] & nxt_enables)) || wr_cause[`FEFC_CAUSE_E]);

	// cause vector of the reported instruction, E from the flush unit
	assign op_cause        = {fl.unimpl, op_ieee_exc};
	assign op_enabled_hits = op_ieee_exc & nxt_enables;
	assign op_trap         = op_valid &&
		((|op_enabled_hits) || fl.unimpl);

	// ----------------------------------------
	// cause and flag update
	// ----------------------------------------
	// an op in the same cycle as a write overrides the written cause
	// and, unless the op traps, its flag bits are or-ed on top
	always_comb begin
		nxt_cause = wr_cause;
		nxt_flags = wr_flags;
		if (op_valid) begin
			nxt_cause = op_cause;
			if (!op_trap) begin
				nxt_flags = nxt_flags | op_ieee_exc;
			end
		end
	end

	// ----------------------------------------
	// decision and trap outputs
	// ----------------------------------------
	always_comb begin
		nxt_trap           = op_trap || wr_trap;
		nxt_trap_unimpl    = (op_valid && fl.unimpl) ||
			(wr_trap && wr_cause[`FEFC_CAUSE_E]);
		nxt_flush_operands = 1'b0;
		nxt_inter_force    = fefc_pkg::FEFC_FORCE_NONE;
		nxt_final_force    = fefc_pkg::FEFC_FORCE_NONE;
		nxt_result_sign    = result_sign_ff;
		if (op_valid) begin
			nxt_flush_operands = fl.flush_operands;
			nxt_inter_force    = fl.inter_force;
			nxt_final_force    = fl.final_force;
			nxt_result_sign    = op_sign;           // flushed value keeps its sign
		end
	end

	// ----------------------------------------
	// read image
	// ----------------------------------------
	// compliance bits read as one, condition codes and rest as zero
	always_comb begin
		nxt_rd_data                                 = `FEFC_WORD_ZERO;
		nxt_rd_data[`FEFC_FS_BIT]                   = nxt_fs;
		nxt_rd_data[`FEFC_FO_BIT]                   = nxt_fo;
		nxt_rd_data[`FEFC_FN_BIT]                   = nxt_fn;
		nxt_rd_data[`FEFC_ABS_BIT]                  = `FEFC_FIXED_ONE;
		nxt_rd_data[`FEFC_NAN_BIT]                  = `FEFC_FIXED_ONE;
		nxt_rd_data[`FEFC_CAUSE_HI:`FEFC_CAUSE_LO] = nxt_cause;
		nxt_rd_data[`FEFC_EN_HI:`FEFC_EN_LO]       = nxt_enables;
		nxt_rd_data[`FEFC_FLAG_HI:`FEFC_FLAG_LO]   = nxt_flags;
		nxt_rd_data[`FEFC_RM_HI:`FEFC_RM_LO]       = nxt_rm;
	end

	// ----------------------------------------
	// register state
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cause_ff              <= `FEFC_CAUSE_RST;
			enables_ff            <= `FEFC_EN_RST;
			flags_ff              <= `FEFC_FLAG_RST;
			flush_to_zero_ctl_ff  <= `FEFC_CTL_RST;
			flush_override_ctl_ff <= `FEFC_CTL_RST;
			flush_nearest_ctl_ff  <= `FEFC_CTL_RST;
			rounding_field_ff     <= `FEFC_RM_RST;
		end else begin
			cause_ff              <= nxt_cause;
			enables_ff            <= nxt_enables;
			flags_ff              <= nxt_flags;
			flush_to_zero_ctl_ff  <= nxt_fs;
			flush_override_ctl_ff <= nxt_fo;
			flush_nearest_ctl_ff  <= nxt_fn;
			rounding_field_ff     <= nxt_rm;
		end
	end

	// ----------------------------------------
	// output registers
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			csr_rd_data_ff    <= `FEFC_WORD_ZERO;
			trap_ff           <= 1'b0;
			trap_unimpl_ff    <= 1'b0;
			flush_operands_ff <= 1'b0;
			inter_force_ff    <= fefc_pkg::FEFC_FORCE_NONE;
			final_force_ff    <= fefc_pkg::FEFC_FORCE_NONE;
			result_sign_ff    <= 1'b0;
		end else begin
			csr_rd_data_ff    <= nxt_rd_data;
			trap_ff           <= nxt_trap;
			trap_unimpl_ff    <= nxt_trap_unimpl;
			flush_operands_ff <= nxt_flush_operands;
			inter_force_ff    <= nxt_inter_force;
			final_force_ff    <= nxt_final_force;
			result_sign_ff    <= nxt_result_sign;
		end
	end

endmodule // fefc_exc_ctrl

// [dv/fefc_exc_ctrl_asserts.sv]
/* checker for the fp control/status block: traps, flags, flush outputs.
   assumes: bound to fefc_exc_ctrl, one clock, synchronous reset. */
`timescale 1ns/10ps
module fefc_exc_ctrl_asserts (
	input wire logic        core_clk,
	input wire logic        rst,
	input wire logic        csr_wr_en,
	input wire logic [1:0]  csr_wr_view,
	input wire logic [31:0] csr_wr_data,
	input wire logic        op_valid,
	input wire logic [1:0]  op_kind,
	input wire logic [4:0]  op_ieee_exc,
	input wire logic        op_denorm_in,
	input wire logic        op_tiny_inter,
	input wire logic        op_tiny_final,
	input wire logic        op_sign,
	input wire logic        op_below_half,
	input wire logic [31:0] csr_rd_data_ff,
	input wire logic        trap_ff,
	input wire logic        trap_unimpl_ff,
	input wire logic        flush_operands_ff,
	input wire logic [1:0]  inter_force_ff,
	input wire logic [1:0]  final_force_ff,
	input wire logic        result_sign_ff,
	input wire logic [1:0]  rounding_field_ff
);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	logic op_only;
	logic wr_only;
	// requests that arrive alone; writes only through the full view
	assign op_only = op_valid && !csr_wr_en;
	assign wr_only = csr_wr_en && !op_valid && (csr_wr_view == 2'h0);

	a_trap_has_cause: assert property (trap_ff |-> $past(op_valid || csr_wr_en))
		else $error("trap without a request");
	a_write_trap: assert property (wr_only && |(csr_wr_data[16:12] & csr_wr_data[11:7]) |=> trap_ff)
		else $error("write with enabled cause gave no trap");
	a_unimpl_always: assert property (wr_only && csr_wr_data[17] |=> trap_ff && trap_unimpl_ff)
		else $error("unimplemented cause did not trap");
	a_cause_update: assert property (op_only |=> csr_rd_data_ff[16:12] == $past(op_ieee_exc))
		else $error("cause field not from last op");
	a_flag_set: assert property (op_only && op_kind == 2'h1 && !op_denorm_in && !op_tiny_final
		&& (op_ieee_exc & csr_rd_data_ff[11:7]) == 5'h00
		|=> csr_rd_data_ff[6:2] == ($past(csr_rd_data_ff[6:2]) | $past(op_ieee_exc)))
		else $error("untrapped exception flags wrong");
	a_trap_keeps_flags: assert property (op_only && |(op_ieee_exc & csr_rd_data_ff[11:7])
		|=> $stable(csr_rd_data_ff[6:2]))
		else $error("trapped op changed flags");
	a_flags_sticky: assert property (!csr_wr_en |=>
		(~csr_rd_data_ff[6:2] & $past(csr_rd_data_ff[6:2])) == 5'h00)
		else $error("flag cleared without a write");
	a_round_field: assert property (rounding_field_ff == csr_rd_data_ff[1:0])
		else $error("rounding output differs from field");
	a_no_unimpl_other: assert property (op_only && (op_kind == 2'h0 || op_kind == 2'h3)
		|=> !trap_unimpl_ff)
		else $error("unimplemented trap on unaffected op");
	a_flush_operand: assert property (op_only && op_kind != 2'h0 && op_denorm_in
		&& csr_rd_data_ff[24] |=> flush_operands_ff)
		else $error("denormal operand not flushed");
	a_override_keeps: assert property (op_only && op_kind == 2'h2 && csr_rd_data_ff[22]
		|=> inter_force_ff == 2'h0)
		else $error("override still forced intermediate");
	a_nearest_flush: assert property (op_only && op_kind == 2'h1 && op_tiny_final
		&& csr_rd_data_ff[21] && csr_rd_data_ff[1:0] == 2'h0
		|=> final_force_ff == ($past(op_below_half) ? 2'h1 : 2'h2))
		else $error("nearest flush value wrong");
	c_tiny_op: cover property (op_only && op_tiny_final);
	c_unimpl: cover property (trap_unimpl_ff);
	c_view3: cover property (csr_wr_en && csr_wr_view == 2'h3);
endmodule // fefc_exc_ctrl_asserts

bind fefc_exc_ctrl fefc_exc_ctrl_asserts u_asserts (.core_clk, .rst, .csr_wr_en, .csr_wr_view,
	.csr_wr_data, .op_valid, .op_kind, .op_ieee_exc, .op_denorm_in, .op_tiny_inter,
	.op_tiny_final, .op_sign, .op_below_half, .csr_rd_data_ff, .trap_ff, .trap_unimpl_ff,
	.flush_operands_ff, .inter_force_ff, .final_force_ff, .result_sign_ff, .rounding_field_ff);

// [dv/fefc_core_model.sv]
/* core-side model: issues register writes and arithmetic op reports.
   assumes: one request per cycle, driven on the falling edge. */
`timescale 1ns/10ps
module fefc_core_model (
	input  wire logic        core_clk,
	output logic             csr_wr_en,
	output logic      [1:0]  csr_wr_view,
	output logic      [31:0] csr_wr_data,
	output logic             op_valid,
	output logic      [1:0]  op_kind,
	output logic      [4:0]  op_ieee_exc,
	output logic      [4:0]  op_bits
);
	// ----------------------------------------
	// request tasks
	// ----------------------------------------
	// quiet bus at time zero
	initial begin
		{csr_wr_en, csr_wr_view, csr_wr_data, op_valid, op_kind, op_ieee_exc, op_bits} = '0;
	end
	// register move; the only way software clears flags
	task automatic wr(input logic [1:0] v, input logic [31:0] d);
		@(negedge core_clk);
		{csr_wr_en, csr_wr_view, csr_wr_data, op_valid} = {1'b1, v, d, 1'b0};
	endtask
	// op report, b = {denorm, tiny_inter, tiny_final, sign, below_half}
	task automatic op(input logic [1:0] k, input logic [4:0] x, input logic [4:0] b);
		@(negedge core_clk);
		{op_valid, op_kind, op_ieee_exc, op_bits, csr_wr_en} = {1'b1, k, x, b, 1'b0};
	endtask
	// drop both strobes
	task automatic idle();
		@(negedge core_clk);
		{op_valid, csr_wr_en} = 2'h0;
	endtask
endmodule // fefc_core_model

// [dv/tb_top.sv]
/* self-checking bench for the fp control/status block.
   assumes: core model drives requests, notes are checked one cycle on. */
`timescale 1ns/10ps
module tb_top;
	logic        core_clk, rst, csr_wr_en, op_valid, taken;
	logic        op_denorm_in, op_tiny_inter, op_tiny_final, op_sign, op_below_half;
	logic [1:0]  csr_wr_view, op_kind, rm_m;
	logic [31:0] csr_wr_data, csr_rd_data_ff;
	logic [4:0]  op_ieee_exc, op_bits, en_m, fl_m;
	logic [5:0]  cause_m;
	logic        fs_m, fo_m, fn_m, sg_m;
	logic        trap_ff, trap_unimpl_ff, flush_operands_ff, result_sign_ff;
	logic [1:0]  inter_force_ff, final_force_ff, rounding_field_ff;
	logic [39:0] exq[$];
	int          n_errors, checks_done;

	assign {op_denorm_in, op_tiny_inter, op_tiny_final, op_sign, op_below_half} = op_bits;
	fefc_exc_ctrl u_dut (.core_clk, .rst, .csr_wr_en, .csr_wr_view, .csr_wr_data, .op_valid,
		.op_kind, .op_ieee_exc, .op_denorm_in, .op_tiny_inter, .op_tiny_final, .op_sign,
		.op_below_half, .csr_rd_data_ff, .trap_ff, .trap_unimpl_ff, .flush_operands_ff,
		.inter_force_ff, .final_force_ff, .result_sign_ff, .rounding_field_ff);
	fefc_core_model u_core (.core_clk, .csr_wr_en, .csr_wr_view, .csr_wr_data, .op_valid,
		.op_kind, .op_ieee_exc, .op_bits);

	// ----------------------------------------
	// expectation model
	// ----------------------------------------
	function automatic logic [31:0] img();
		return {7'h00, fs_m, 1'b0, fo_m, fn_m, 3'h3, cause_m, en_m, fl_m, rm_m};
	endfunction
	task automatic do_wr(input logic [1:0] v, input logic [31:0] d);
		logic tr;
		case (v)
			2'h0: {fs_m, fo_m, fn_m, cause_m, en_m, fl_m, rm_m} = {d[24], d[22:21], d[17:0]};
			2'h1: {cause_m, fl_m} = {d[17:12], d[6:2]};
			2'h2: {en_m, fs_m, rm_m} = {d[11:7], d[2:0]};
			default: ;
		endcase
		tr = (|(cause_m[4:0] & en_m)) | cause_m[5];
		exq.push_back({tr, cause_m[5], 3'h0, sg_m, rm_m, img()});
		u_core.wr(v, d);
	endtask
	task automatic do_op(input logic [1:0] k, input logic [4:0] x, input logic [4:0] b);
		logic e, tr;
		logic [1:0] ff;
		e = (k == 2'h1 || k == 2'h2) && !fs_m && (b[4] || (b[2] && !fn_m)
			|| (k == 2'h2 && b[3] && !fo_m));
		tr = (|(x & en_m)) | e;
		ff = fefc_pkg::FEFC_FORCE_NONE;
		if (b[2] && k != 2'h0 && (fs_m || fn_m)) begin
			if (fn_m && rm_m == 2'h0) ff = b[0] ? fefc_pkg::FEFC_FORCE_ZERO : fefc_pkg::FEFC_FORCE_MIN_NORM;
			else if ((rm_m == 2'h2 && !b[1]) || (rm_m == 2'h3 && b[1])) ff = fefc_pkg::FEFC_FORCE_MIN_NORM;
			else ff = fefc_pkg::FEFC_FORCE_ZERO;
		end
		cause_m = {e, x};
		if (!tr) fl_m = fl_m | x;
		sg_m = b[1];
		exq.push_back({tr, e, fs_m && k != 2'h0, ff, sg_m, rm_m, img()});
		u_core.op(k, x, b);
	endtask
	task automatic cmp(input logic [39:0] g, input logic [39:0] e);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic close_out();
		if (n_errors == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// ----------------------------------------
	// clock, monitor, watchdog, sequence
	// ----------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	always @(posedge core_clk) taken <= (csr_wr_en || op_valid) && !rst;
	// answer one cycle after each request against the oldest note
	always @(negedge core_clk) begin
		if (taken === 1'b1) cmp({trap_ff, trap_unimpl_ff, flush_operands_ff, final_force_ff,
			result_sign_ff, rounding_field_ff, csr_rd_data_ff},
			(exq.size() > 0) ? exq.pop_front() : 40'h00_0000_0000);
	end
	initial begin
		#(40 * 3000);
		n_errors++;
		close_out();
	end
	initial begin
		void'($urandom(32'h4fdc_64c6));
		rst = 1'b1;
		{fs_m, fo_m, fn_m, sg_m, cause_m, en_m, fl_m, rm_m} = '0;
		repeat (20) @(negedge core_clk);
		rst = 1'b0;
		@(negedge core_clk);
		cmp({8'h00, csr_rd_data_ff}, 40'h00_000C_0000);
		// each cause alone, enables off then on
		for (int i = 0; i < 6; i++) begin
			do_wr(2'h0, 32'h0000_1000 << i);
			do_wr(2'h0, (32'h0000_1000 << i) | 32'h0000_0F80);
		end
		do_wr(2'h3, 32'hFFFF_FFFF);
		do_wr(2'h0, 32'h0000_0000);
		do_wr(2'h3, 32'hFFFF_FFFF);
		do_wr(2'h1, 32'h0003_F07C);
		do_wr(2'h2, 32'h0000_0F87);
		// every rounding mode, sign and half point, zero and nearest flush
		for (int j = 0; j < 32; j++) begin
			do_wr(2'h0, (j[4] ? 32'h0020_0000 : 32'h0100_0000) | 32'(j[3:2]));
			do_op(2'h1, 5'h00, {3'h1, 2'(j)});
		end
		// each op class with denormal, tiny intermediate, tiny final
		for (int k = 0; k < 24; k++) begin
			if (k % 12 == 0) do_wr(2'h0, (k != 0) ? 32'h0100_0000 : 32'h0000_0000);
			do_op(2'((k % 12) / 3), 5'h00, 5'h10 >> (k % 3));
		end
		do_wr(2'h0, 32'h0040_0000);
		do_op(2'h2, 5'h00, 5'h08);
		// sticky flags, a trapped op, then a clearing write
		do_wr(2'h0, 32'h0000_0800);
		do_op(2'h1, 5'h01, 5'h00);
		do_op(2'h1, 5'h02, 5'h00);
		do_op(2'h1, 5'h11, 5'h00);
		do_wr(2'h0, 32'h0000_0000);
		for (int i = 0; i < 300; i++) begin
			if ($urandom_range(3) == 0) do_wr(2'($urandom_range(3)), $urandom & 32'h0163_FFFF);
			else do_op(2'($urandom_range(3)), 5'($urandom), 5'($urandom) & {!(fn_m && !fs_m), 4'hF});
		end
		u_core.idle();
		repeat (2) @(negedge core_clk);
		close_out();
	end
endmodule // tb_top
